// File: core/pin_sync.sv
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 2
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] reset_level,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
    logic         seeded_q;

    always_comb begin
        lvl_d = lvl_q;
        if (!seeded_q) begin
            lvl_d = reset_level;
        end
        for (int i = 0; i < W; i++) begin
            if (seeded_q && (s2_q[i] == s3_q[i])) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            // Seeding every stage avoids a false pin change right after reset.
            s1_q     <= reset_level;
            s2_q     <= reset_level;
            s3_q     <= reset_level;
            lvl_q    <= reset_level;
            seeded_q <= 1'b0;
        end else begin
            s1_q     <= pin_in;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            lvl_q    <= lvl_d;
            seeded_q <= 1'b1;
        end
    end

    assign level_out = lvl_q;
endmodule

// File: core/servo_stop_and_brake_sequencer.sv
// Servo stop, dynamic brake and holding brake sequencer with a Wishbone register file.
`timescale 1ns/1ps
`include "servo_stop_defines.svh"
module servo_stop_and_brake_sequencer
    import servo_stop_pkg::*;
#(
    parameter int TICK_CYCLES   = `TICK_CYCLES,
    parameter int SPEED_W       = 14,
    parameter int LOW_SPEED_RPM = `LOW_SPEED_RPM
) (
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               main_power_ok_pin,
    input  wire logic               control_power_ok_pin,
    input  wire logic               servo_alarm_in,
    input  wire logic               enc_backup_alarm_evt,
    input  wire logic               enc_checksum_alarm_evt,
    input  wire logic               enc_other_alarm_evt,
    input  wire logic               encoder_usage_sel,
    input  wire logic [SPEED_W-1:0] motor_speed_rpm,
    input  wire logic [SPEED_W-1:0] motor_max_rpm,
    input  wire logic [2:0]         gp_status_in,
    output logic                    motor_enable,
    output logic                    dynamic_brake,
    output logic                    brake_interlock_out,
    output logic      [2:0]         gp_out_level,
    output logic                    encoder_reset_pulse,
    output logic                    encoder_absolute_mode
);
    localparam logic [SPEED_W-1:0] LOW_SPD = SPEED_W'(LOW_SPEED_RPM);

    if (SPEED_W < 14 || LOW_SPEED_RPM < 0 || LOW_SPEED_RPM >= 10000) begin : g_bad
        $error("Speed width must hold 10000 RPM and the low speed must be below it.");
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Register file.
    logic [7:0]  ctrl_q, ctrl_d;
    logic [5:0]  delay_q, delay_d;
    logic [6:0]  wait_q, wait_d;
    logic [13:0] level_q, level_d;
    logic [31:0] rdata_q, rdata_d, wimg, status;
    logic        ack_q, ack_d, hit, wr;
    logic [3:0]  cmd;

    assign hit = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = hit & wb_we_i;

    always_comb begin
        ctrl_d  = ctrl_q;
        delay_d = delay_q;
        wait_d  = wait_q;
        level_d = level_q;
        rdata_d = rdata_q;
        ack_d   = hit;
        cmd     = 4'h0;
        wimg    = 32'h0000_0000;
        unique case (wb_adr_i)
            `ADDR_CTRL: begin
                wimg = merge({24'h0, ctrl_q}, wb_dat_i, wb_sel_i);
                if (wr) begin
                    ctrl_d = wimg[7:0];
                end
            end
            `ADDR_TIMING: begin
                wimg = merge({17'h0, wait_q, 2'h0, delay_q}, wb_dat_i, wb_sel_i);
                if (wr) begin
                    delay_d = (wimg[5:0] > `DELAY_MAX) ? `DELAY_MAX : wimg[5:0];
                    wait_d  = (wimg[14:8] < `WAIT_MIN) ? `WAIT_MIN :
                              (wimg[14:8] > `WAIT_MAX) ? `WAIT_MAX : wimg[14:8];
                end
            end
            `ADDR_SPEED: begin
                wimg = merge({18'h0, level_q}, wb_dat_i, wb_sel_i);
                if (wr) begin
                    level_d = (wimg[13:0] > `LEVEL_MAX) ? `LEVEL_MAX : wimg[13:0];
                end
            end
            `ADDR_CMD: begin
                if (wr && wb_sel_i[0]) begin
                    cmd = wb_dat_i[3:0];
                end
            end
            default: begin
                wimg = 32'h0000_0000;
            end
        endcase
        if (hit && !wb_we_i) begin
            unique case (wb_adr_i)
                `ADDR_CTRL:   rdata_d = {24'h0, ctrl_q};
                `ADDR_TIMING: rdata_d = {17'h0, wait_q, 2'h0, delay_q};
                `ADDR_SPEED:  rdata_d = {18'h0, level_q};
                `ADDR_STATUS: rdata_d = status;
                default:      rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_q  <= `CTRL_RESET;
            delay_q <= `DELAY_RESET;
            wait_q  <= `WAIT_RESET;
            level_q <= `LEVEL_RESET;
            rdata_q <= 32'h0000_0000;
            ack_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            delay_q <= delay_d;
            wait_q  <= wait_d;
            level_q <= level_d;
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // Power pins arrive from outside the clock domain.
    logic [1:0] pwr;
    logic       main_ok, ctrl_ok;

    pin_sync #(.W(2)) u_pwr_sync (
        .clock       (clock),
        .rst_n       (rst_n),
        .pin_in      ({control_power_ok_pin, main_power_ok_pin}),
        .reset_level (2'b11),
        .level_out   (pwr)
    );

    assign main_ok = pwr[0];
    assign ctrl_ok = pwr[1];

    // Sequencer and alarm state.
    seq_state_t         st_q, st_d;
    stop_mode_t         mode_q, mode_d;
    logic [5:0]         sdelay_q, sdelay_d;
    logic [6:0]         swait_q, swait_d, cnt_q, cnt_d;
    logic [13:0]        slevel_q, slevel_d;
    logic [SPEED_W-1:0] eff_level;
    logic               db_hold_q, db_hold_d, tick, restart;
    logic               alm_q, alm_d, bkp_q, bkp_d, chk_q, chk_d, oth_q, oth_d;
    logic               noop_q, noop_d, done_q, done_d, reboot_q, reboot_d;
    logic               abs_q, abs_d, seen_q, enc_rst_q, enc_rst_d;
    logic               fault, stopped, mtc_ok;

    tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
        .clock   (clock),
        .rst_n   (rst_n),
        .restart (restart),
        .tick    (tick)
    );

    assign fault   = alm_q | bkp_q | chk_q | oth_q | ~main_ok;
    assign stopped = motor_speed_rpm <= LOW_SPD;
    assign eff_level = (SPEED_W'(slevel_q) > motor_max_rpm) ? motor_max_rpm
                                                            : SPEED_W'(slevel_q);
    assign mtc_ok  = cmd[`CMD_MTC_BIT] && st_q == ST_OFF && !ctrl_q[`CTRL_WP_BIT];

    always_comb begin
        st_d      = st_q;
        mode_d    = mode_q;
        sdelay_d  = sdelay_q;
        swait_d   = swait_q;
        slevel_d  = slevel_q;
        cnt_d     = cnt_q;
        db_hold_d = db_hold_q;
        restart   = 1'b0;
        unique case (st_q)
            ST_OFF: begin
                if (mode_q == SM_DB_COAST && stopped) begin
                    db_hold_d = 1'b0;
                end
                if (cmd[`CMD_ON_BIT] && !fault && !reboot_q) begin
                    st_d      = ST_ON;
                    db_hold_d = 1'b0;
                end
            end
            ST_ON: begin
                if (cmd[`CMD_OFF_BIT] || fault) begin
                    mode_d    = stop_mode_t'(ctrl_q[`CTRL_MODE_LSB +: 2]);
                    sdelay_d  = delay_q;
                    swait_d   = wait_q;
                    slevel_d  = level_q;
                    cnt_d     = 7'h00;
                    restart   = 1'b1;
                    // Dynamic braking only for modes 0 and 1 and only if still moving.
                    db_hold_d = !ctrl_q[`CTRL_MODE_LSB + 1] && !stopped;
                    if (!stopped) begin
                        st_d = ST_RUN;
                    end else if (fault || delay_q == 6'h00) begin
                        st_d = ST_OFF;
                    end else begin
                        st_d = ST_HOLD;
                    end
                end
            end
            ST_HOLD: begin
                if (tick) begin
                    cnt_d = cnt_q + 7'h01;
                end
                if (fault) begin
                    st_d = ST_OFF;
                end else if (tick && (cnt_q + 7'h01) >= {1'b0, sdelay_q}) begin
                    st_d = ST_OFF;
                end
            end
            ST_RUN: begin
                if (tick) begin
                    cnt_d = cnt_q + 7'h01;
                end
                if (motor_speed_rpm < eff_level || cnt_q >= swait_q) begin
                    st_d = ST_OFF;
                end
            end
        endcase
    end

    always_comb begin
        alm_d     = servo_alarm_in | (alm_q & ~cmd[`CMD_CLR_BIT]);
        // Setup clears the backup and checksum encoder alarms, the host clear command never does.
        bkp_d     = enc_backup_alarm_evt | (bkp_q & ~mtc_ok);
        chk_d     = enc_checksum_alarm_evt | (chk_q & ~mtc_ok);
        oth_d     = enc_other_alarm_evt | oth_q;
        noop_d    = noop_q;
        done_d    = done_q | mtc_ok;
        reboot_d  = reboot_q | mtc_ok;
        enc_rst_d = mtc_ok;
        abs_d     = seen_q ? abs_q : ~encoder_usage_sel;
        if (cmd[`CMD_MTC_BIT] && st_q == ST_OFF) begin
            noop_d = ctrl_q[`CTRL_WP_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q      <= ST_OFF;
            mode_q    <= SM_DB_HOLD;
            sdelay_q  <= `DELAY_RESET;
            swait_q   <= `WAIT_RESET;
            slevel_q  <= `LEVEL_RESET;
            cnt_q     <= 7'h00;
            db_hold_q <= 1'b0;
            alm_q     <= 1'b0;
            bkp_q     <= 1'b0;
            chk_q     <= 1'b0;
            oth_q     <= 1'b0;
            noop_q    <= 1'b0;
            done_q    <= 1'b0;
            reboot_q  <= 1'b0;
            abs_q     <= 1'b0;
            seen_q    <= 1'b0;
            enc_rst_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            mode_q    <= mode_d;
            sdelay_q  <= sdelay_d;
            swait_q   <= swait_d;
            slevel_q  <= slevel_d;
            cnt_q     <= cnt_d;
            db_hold_q <= db_hold_d;
            alm_q     <= alm_d;
            bkp_q     <= bkp_d;
            chk_q     <= chk_d;
            oth_q     <= oth_d;
            noop_q    <= noop_d;
            done_q    <= done_d;
            reboot_q  <= reboot_d;
            abs_q     <= abs_d;
            seen_q    <= 1'b1;
            enc_rst_q <= enc_rst_d;
        end
    end

    // Output stage; every pin level comes from a flip-flop.
    logic       men_q, men_d, db_q, db_d, bk_q, bk_d;
    logic [2:0] gp_q, gp_d;
    logic [1:0] route;

    assign route = ctrl_q[`CTRL_ROUTE_LSB +: 2];

    always_comb begin
        men_d = (st_d == ST_ON) || (st_d == ST_HOLD);
        bk_d  = (st_d == ST_ON) || (st_d == ST_RUN);
        // With both supplies gone the shorting relay falls in regardless of mode.
        db_d  = (!men_d && db_hold_d) || (!ctrl_ok && !main_ok);
        for (int k = 0; k < 3; k++) begin
            // Active means pin closed, which is the low level unless the pin's reverse bit in ctrl_q is set.
            gp_d[k] = ~(gp_status_in[k] | (bk_d && route == 2'(k + 1)))
                      ^ ctrl_q[`CTRL_REV_LSB + k];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            men_q <= 1'b0;
            db_q  <= 1'b0;
            bk_q  <= 1'b0;
            gp_q  <= 3'h7;
        end else begin
            men_q <= men_d;
            db_q  <= db_d;
            bk_q  <= bk_d;
            gp_q  <= gp_d;
        end
    end

    assign status = {18'h0, abs_q, reboot_q, done_q, noop_q, oth_q, chk_q, bkp_q, alm_q,
                     bk_q, db_q, men_q, 1'b0, st_q};

    assign motor_enable          = men_q;
    assign dynamic_brake         = db_q;
    assign brake_interlock_out   = bk_q;
    assign gp_out_level          = gp_q;
    assign encoder_reset_pulse   = enc_rst_q;
    assign encoder_absolute_mode = abs_q;
endmodule

// File: core/tick_gen.sv
// Restartable divider that gives a one-cycle enable every CYCLES clocks.
`timescale 1ns/1ps
module tick_gen #(
    parameter int CYCLES = 400000
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic restart,
    output logic      tick
);
    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_q, cnt_d;
    logic          tick_q, tick_d;

    if (CYCLES < 2) begin : g_bad
        $error("tick_gen needs at least two cycles per tick.");
    end

    always_comb begin
        cnt_d  = cnt_q + 1'b1;
        tick_d = 1'b0;
        if (restart) begin
            cnt_d = '0;
        end else if (cnt_q == LAST) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule

// File: pkg/servo_stop_defines.svh
// Register offsets, field positions, reset values and timing counts of the stop sequencer.
`ifndef SERVO_STOP_DEFINES_SVH
`define SERVO_STOP_DEFINES_SVH
`define CLK_HZ            40000000
`define TICK_MS           10
`define TICK_CYCLES       ((`CLK_HZ / 1000) * `TICK_MS)
`define LOW_SPEED_RPM     2
`define ADDR_CTRL         8'h00
`define ADDR_TIMING       8'h04
`define ADDR_SPEED        8'h08
`define ADDR_CMD          8'h0C
`define ADDR_STATUS       8'h10
`define CTRL_MODE_LSB     0
`define CTRL_ROUTE_LSB    2
`define CTRL_REV_LSB      4
`define CTRL_WP_BIT       7
`define CTRL_RESET        8'h04
`define TIM_DELAY_LSB     0
`define TIM_WAIT_LSB      8
`define DELAY_RESET       6'h00
`define DELAY_MAX         6'h32
`define WAIT_RESET        7'h32
`define WAIT_MIN          7'h0A
`define WAIT_MAX          7'h64
`define LEVEL_RESET       14'h0064
`define LEVEL_MAX         14'h2710
`define CMD_ON_BIT        0
`define CMD_OFF_BIT       1
`define CMD_CLR_BIT       2
`define CMD_MTC_BIT       3
`endif

// File: pkg/servo_stop_pkg.sv
// Types shared by the stop and brake sequencer files.
package servo_stop_pkg;
    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,
        ST_ON   = 2'b01,
        ST_HOLD = 2'b10,
        ST_RUN  = 2'b11
    } seq_state_t;
    typedef enum logic [1:0] {
        SM_DB_HOLD  = 2'b00,
        SM_DB_COAST = 2'b01,
        SM_COAST    = 2'b10,
        SM_SPARE    = 2'b11
    } stop_mode_t;
endpackage

// File: testbench/motor_relay_model.sv
// Motor and brake relay stand-in that spins up under drive and slows when left alone.
`timescale 1ns/1ps
module motor_relay_model (
    input  wire logic        clock,
    input  wire logic        motor_enable,
    input  wire logic        dynamic_brake,
    input  wire logic        brake_interlock_out,
    input  wire logic [13:0] target_rpm,
    output logic      [13:0] speed_rpm,
    output logic             brake_held
);
    initial speed_rpm = 14'h0000;
    // The relay drops out and the holding brake bites while the interlock is off.
    assign brake_held = ~brake_interlock_out;
    always @(posedge clock) begin
        if (motor_enable) begin
            speed_rpm <= target_rpm;
        end else if (speed_rpm != 14'h0000) begin
            // Shorted windings slow the rotor far faster than friction alone.
            speed_rpm <= (dynamic_brake && speed_rpm > 14'h0008) ? speed_rpm - 14'h0008
                       : speed_rpm - 14'h0001;
        end
    end
endmodule

// File: testbench/servo_stop_checker_sva.sv
// Port-level assertions for the stop and brake sequencer, bound to its top module.
`timescale 1ns/1ps
module servo_stop_checker #(
    parameter int TICK_CYCLES = 400000
) (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        main_power_ok_pin,
    input wire logic        control_power_ok_pin,
    input wire logic        servo_alarm_in,
    input wire logic        motor_enable,
    input wire logic        dynamic_brake,
    input wire logic        brake_interlock_out,
    input wire logic        encoder_reset_pulse,
    input wire logic        encoder_absolute_mode
);
    default clocking dflt @(posedge clock); endclocking
    default disable iff (!rst_n);
    // A running stop may keep the brake released only up to the longest wait.
    int coast_q;
    int coast_d;
    always_comb begin
        coast_d = (!motor_enable && brake_interlock_out) ? coast_q + 1 : 0;
    end
    always_ff @(posedge clock) begin
        coast_q <= rst_n ? coast_d : 0;
    end
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered after one cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge held too long");
    cmd_read_zero_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h0C
        |-> wb_dat_o == 32'h0000_0000) else $error("command register read not zero");
    main_loss_off_a: assert property (!main_power_ok_pin [*8] |-> !motor_enable)
        else $error("motor still driven without main power");
    power_loss_brake_a: assert property (
        (!main_power_ok_pin && !control_power_ok_pin) [*8] |-> dynamic_brake)
        else $error("dynamic brake off with both supplies lost");
    alarm_stop_a: assert property ($rose(servo_alarm_in) |-> ##[1:3] !motor_enable)
        else $error("motor not stopped promptly on alarm");
    brake_apply_bound_a: assert property (coast_q <= 101 * TICK_CYCLES + 8)
        else $error("brake not applied within the waiting time");
    release_needs_enable_a: assert property ($rose(brake_interlock_out) |-> motor_enable)
        else $error("brake released with motor unpowered");
    abs_mode_fixed_a: assert property ($changed(encoder_absolute_mode) |-> !$past(rst_n, 2))
        else $error("encoder mode changed without restart");
    setup_pulse_single_a: assert property (encoder_reset_pulse |=> !encoder_reset_pulse)
        else $error("encoder setup pulse too long");
endmodule
bind servo_stop_and_brake_sequencer servo_stop_checker #(.TICK_CYCLES(TICK_CYCLES))
    servo_stop_checker_inst (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .main_power_ok_pin(main_power_ok_pin),
    .control_power_ok_pin(control_power_ok_pin), .servo_alarm_in(servo_alarm_in),
    .motor_enable(motor_enable), .dynamic_brake(dynamic_brake),
    .brake_interlock_out(brake_interlock_out), .encoder_reset_pulse(encoder_reset_pulse),
    .encoder_absolute_mode(encoder_absolute_mode));

// File: testbench/testbench.sv
// Self-checking bench for the stop and brake sequencer.
`timescale 1ns/1ps
module testbench;
    logic        clock, rst_n, cyc_o, stb_o, we_o, ack, main_ok, ctl_ok, alarm, bk_ev, cs_ev;
    logic        ot_ev, usage, m_en, d_brk, bk_out, r_pulse, abs_md, held;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, q_o, rdat;
    logic [13:0] speed, max_rpm, target;
    logic [2:0]  gp_in, gp_lvl;
    int          miscompares, tests_run, cyc, pulses;
    servo_stop_and_brake_sequencer #(.TICK_CYCLES(20)) servo_stop_and_brake_sequencer_inst (
        .clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc_o), .wb_stb_i(stb_o), .wb_we_i(we_o),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q_o), .wb_ack_o(ack),
        .main_power_ok_pin(main_ok), .control_power_ok_pin(ctl_ok), .servo_alarm_in(alarm),
        .enc_backup_alarm_evt(bk_ev), .enc_checksum_alarm_evt(cs_ev),
        .enc_other_alarm_evt(ot_ev), .encoder_usage_sel(usage), .motor_speed_rpm(speed),
        .motor_max_rpm(max_rpm), .gp_status_in(gp_in), .motor_enable(m_en),
        .dynamic_brake(d_brk), .brake_interlock_out(bk_out), .gp_out_level(gp_lvl),
        .encoder_reset_pulse(r_pulse), .encoder_absolute_mode(abs_md));
    motor_relay_model motor_relay_model_inst (.clock(clock), .motor_enable(m_en),
        .dynamic_brake(d_brk), .brake_interlock_out(bk_out), .target_rpm(target),
        .speed_rpm(speed), .brake_held(held));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (r_pulse === 1'b1) pulses <= pulses + 1;
    end
    task automatic wait_n(input int n); repeat (n) @(posedge clock); endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Holds the request until ack is sampled; the slave answer time is not assumed.
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        rdat = q_o;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 32'h0);
        check("register", rdat, exp);
    endtask
    task automatic rd_st(input logic [31:0] exp);
        wb(8'h10, 1'b0, 32'h0);
        check("status", rdat & 32'h0FC0, exp);
    endtask
    task automatic cmd(input int b); wb(8'h0C, 1'b1, 32'h1 << b); endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_reset();
        wait_n(3);
        check("abs mode", abs_md, 32'h1);
        check("outputs", {m_en, bk_out, gp_lvl}, 32'h07);
        rd(8'h00, 32'h04);
        rd(8'h04, 32'h3200);
        rd(8'h08, 32'h64);
        rd(8'h0C, 32'h0);
        wb(8'h20, 1'b1, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0);
        wb(8'h04, 1'b1, 32'h7F3F);
        rd(8'h04, 32'h6432);
        wb(8'h08, 1'b1, 32'h3FFF);
        rd(8'h08, 32'h2710);
        wb(8'h04, 1'b1, 32'h0500);
        rd(8'h04, 32'h0A00);
        $display("test reset done");
    endtask
    task automatic t_stopped();
        int t0;
        int p0;
        wb(8'h04, 1'b1, 32'h0A03);
        cmd(0);
        wait_n(4);
        check("on", {m_en, bk_out}, 32'h3);
        p0 = pulses;
        cmd(3);
        wait_n(4);
        check("setup while on", pulses - p0, 32'h0);
        cmd(1);
        t0 = cyc;
        wait_n(4);
        check("hold", {m_en, bk_out, d_brk, held}, 32'h9);
        wb(8'h04, 1'b1, 32'h0A32);
        while (m_en !== 1'b0 && cyc - t0 < 300) wait_n(1);
        check("delay", (cyc - t0) inside {[57:65]}, 32'h1);
        wb(8'h04, 1'b1, 32'h0A00);
        cmd(0);
        wait_n(4);
        cmd(1);
        while (bk_out !== 1'b0 && cyc - t0 < 400) wait_n(1);
        check("no delay", m_en, 32'h0);
        $display("test stopped done");
    endtask
    // A stop from 200 rpm; the window bounds when the brake interlock opens.
    task automatic t_run(input logic [1:0] md, input logic [13:0] lvl, input logic db_run,
                         input logic db_end, input int lo, input int hi);
        int t0;
        wb(8'h00, 1'b1, {28'h0, 2'b01, md});
        wb(8'h08, 1'b1, {18'h0, lvl});
        target <= 14'h00C8;
        cmd(0);
        wait_n(4);
        cmd(1);
        t0 = cyc;
        wait_n(3);
        check("run brake", {d_brk, bk_out, m_en}, {29'h0, db_run, 2'b10});
        while (bk_out !== 1'b0 && cyc - t0 < 600) wait_n(1);
        check("stop time", (cyc - t0) inside {[lo:hi]}, 32'h1);
        while (speed !== 14'h0000 && cyc - t0 < 900) wait_n(1);
        wait_n(10);
        check("end brake", d_brk, {31'h0, db_end});
        $display("test run mode %0d done", md);
    endtask
    task automatic t_alarm();
        wb(8'h04, 1'b1, 32'h0A32);
        target <= 14'h0000;
        cmd(0);
        wait_n(4);
        alarm <= 1'b1;
        wait_n(1);
        alarm <= 1'b0;
        wait_n(3);
        check("alarm off", m_en, 32'h0);
        cmd(0);
        wait_n(4);
        check("refused", m_en, 32'h0);
        rd_st(32'h0040);
        cmd(2);
        cmd(0);
        wait_n(4);
        check("on again", m_en, 32'h1);
        wb(8'h00, 1'b1, 32'h06);
        main_ok <= 1'b0;
        wait_n(12);
        check("main lost", {m_en, d_brk}, 32'h0);
        ctl_ok <= 1'b0;
        wait_n(12);
        check("both lost", d_brk, 32'h1);
        main_ok <= 1'b1;
        ctl_ok <= 1'b1;
        wait_n(12);
        $display("test alarm done");
    endtask
    task automatic t_gp();
        logic [7:0] ctl [4] = '{8'h00, 8'h04, 8'h0C, 8'h5C};
        logic [2:0] lvl [4] = '{3'b110, 3'b110, 3'b010, 3'b111};
        wb(8'h04, 1'b1, 32'h0A00);
        gp_in <= 3'b001;
        cmd(0);
        wait_n(4);
        for (int i = 0; i < 4; i++) begin
            wb(8'h00, 1'b1, {24'h0, ctl[i]});
            wait_n(4);
            check("gp level", gp_lvl, {29'h0, lvl[i]});
        end
        cmd(1);
        gp_in <= 3'b000;
        wait_n(4);
        $display("test outputs done");
    endtask
    task automatic t_enc();
        int p0;
        bk_ev <= 1'b1;
        cs_ev <= 1'b1;
        wait_n(1);
        bk_ev <= 1'b0;
        cs_ev <= 1'b0;
        cmd(2);
        rd_st(32'h0180);
        wb(8'h00, 1'b1, 32'h84);
        p0 = pulses;
        cmd(3);
        wait_n(3);
        rd_st(32'h0580);
        check("prohibited", pulses - p0, 32'h0);
        wb(8'h00, 1'b1, 32'h04);
        cmd(3);
        wait_n(3);
        check("setup", pulses - p0, 32'h1);
        rd_st(32'h0800);
        cmd(0);
        wait_n(4);
        check("locked", m_en, 32'h0);
        ot_ev <= 1'b1;
        wait_n(1);
        ot_ev <= 1'b0;
        cmd(2);
        rd_st(32'h0A00);
        usage <= 1'b1;
        rst_n <= 1'b0;
        wait_n(16);
        rst_n <= 1'b1;
        wait_n(3);
        check("incremental", abs_md, 32'h0);
        rd_st(32'h0000);
        cmd(0);
        wait_n(4);
        check("restarted", m_en, 32'h1);
        $display("test encoder done");
    endtask
    initial begin
        {cyc_o, stb_o, we_o, alarm, bk_ev, cs_ev, ot_ev, usage, rst_n} = 9'h000;
        {main_ok, ctl_ok} = 2'b11;
        {adr, sel, dat, gp_in, target} = {8'h00, 4'hF, 32'h0, 3'h0, 14'h0000};
        max_rpm = 14'h1388;
        {miscompares, tests_run, cyc, pulses} = {32'h0, 32'h0, 32'h0, 32'h0};
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_stopped();
        t_run(2'h0, 14'h0064, 1'b1, 1'b1, 10, 22);
        t_run(2'h1, 14'h0064, 1'b1, 1'b0, 10, 22);
        t_run(2'h2, 14'h0064, 1'b0, 1'b0, 96, 110);
        t_run(2'h3, 14'h0064, 1'b0, 1'b0, 96, 110);
        t_run(2'h2, 14'h0000, 1'b0, 1'b0, 195, 206);
        max_rpm <= 14'h0096;
        t_run(2'h2, 14'h2710, 1'b0, 1'b0, 46, 60);
        t_alarm();
        t_gp();
        t_enc();
        end_of_test();
    end
    // The run needs some 1400 cycles, so this limit only trips on a hang.
    initial begin
        repeat (40000) @(posedge clock);
        miscompares++;
        end_of_test();
    end
endmodule
